// ---- rtl/hotplug_slot_regs.sv ----
`include "hotplug_cfg.svh"
`default_nettype none
// Summary of operation
// [RULE_01] Control bit 0 switches the slot B auxiliary output on or off.
// [RULE_02] Control bit 1 switches the slot B main outputs on or off.
// [RULE_03] Control bit 2 at 1 makes slot B power and power-good ignore the override input.
// [RULE_04] Control bits 7 and 6 read the aux and main power-good flags.
// [RULE_05] All three registers hold 00h after reset; every output starts off.
// [RULE_06] Power-good output is the AND of both flags without an override.
// [RULE_07] Active ungated override forces the power-good output to not-good.
// [RULE_08] Commands 03h, 04h, 05h select control B, status A, status B.
// [RULE_09] Status bit 7 reads 1 while the slot fault output pulls low.
// [RULE_10] Status bits 6 and 5 show actual main and aux output state.
// [RULE_11] Status bits 4, 2, 0 set on aux, high, low rail overcurrent.
// [RULE_12] Writing 1 to a set overcurrent bit clears it; the alert drops once no flag stands.
// [RULE_13] Reads and flag clears never change the slot fault output.
// [RULE_14] Main fault clears on main request low, aux fault on aux low.
// [RULE_15] With both faults latched, both requests must go low to clear.
// [RULE_16] Under serial management the fault bit and fault output stay idle.
// [RULE_17] An active slot B override releases the slot B fault output.
// [RULE_18] Slot B status behaves like slot A status with its own pins.
// [RULE_19] Reserved bits read zero and ignore writes.
// [RULE_20] The command byte of a byte write or read is latched as pointer.

module hotplug_slot_regs
    import hotplug_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic smb_cmd_valid,
    input wire logic [7:0] smb_cmd_byte,
    input wire logic smb_write_valid,
    input wire logic [7:0] smb_write_data,
    input wire logic smb_read_valid,
    output logic [7:0] smb_read_data,
    output logic alert_n_drive,
    output logic alert_n_oe,
    input wire logic slot_a_main_request,
    input wire logic slot_a_aux_request,
    input wire logic slot_b_main_request,
    input wire logic slot_b_aux_request,
    input wire logic slot_a_aux_overcurrent,
    input wire logic slot_a_high_rail_overcurrent,
    input wire logic slot_a_low_rail_overcurrent,
    input wire logic slot_b_aux_overcurrent,
    input wire logic slot_b_high_rail_overcurrent,
    input wire logic slot_b_low_rail_overcurrent,
    input wire logic [1:0] serial_management_control,
    input wire logic slot_a_main_power,
    input wire logic slot_a_aux_power,
    input wire logic slot_b_main_good,
    input wire logic slot_b_aux_good,
    input wire logic slot_b_override_n,
    output logic slot_b_main_power,
    output logic slot_b_aux_power,
    output logic slot_b_power_good_n_drive,
    output logic slot_b_power_good_n_oe,
    output logic slot_a_fault_n_drive,
    output logic slot_a_fault_n_oe,
    output logic slot_b_fault_n_drive,
    output logic slot_b_fault_n_oe
);

    pins_s raw;
    pins_s sp;
    slot_pins_s slot_in [2];
    reg_sel_e pointer;
    logic [2:0] ctrl_b;
    logic [2:0] oc_flag [2];
    logic [1:0] main_flt;
    logic [1:0] aux_flt;
    logic [1:0] fault_oe;
    logic [1:0] stat_wr;
    logic [1:0] slot_main_on;
    logic [1:0] slot_aux_on;
    logic ctrl_wr;
    logic override_active;
    logic next_pg_oe;
    logic [1:0] next_fault_oe;

    // Map a command byte onto a register select
    function automatic reg_sel_e decode_cmd(input logic [7:0] cmd);
        case (cmd)
            `CMD_CTRL_B: decode_cmd = SEL_CTRL_B;
            `CMD_STAT_A: decode_cmd = SEL_STAT_A;
            `CMD_STAT_B: decode_cmd = SEL_STAT_B;
            default: decode_cmd = SEL_NONE;
        endcase
    endfunction

    // Assemble a status byte for one slot; reserved bits stay zero
    function automatic logic [7:0] status_word(input logic fault, input logic main_on,
                                               input logic aux_on, input logic [2:0] oc);
        logic [7:0] w;
        w = `REG_RESET;
        w[`ST_FAULT_BIT] = fault;
        w[`ST_MAIN_ON_BIT] = main_on;
        w[`ST_AUX_ON_BIT] = aux_on;
        w[`ST_AUX_OC_BIT] = oc[`OC_AUX];
        w[`ST_HIGH_OC_BIT] = oc[`OC_HIGH];
        w[`ST_LOW_OC_BIT] = oc[`OC_LOW];
        status_word = w;
    endfunction

    // Gather the pins that come from outside the clock domain
    assign raw.a = '{main_req: slot_a_main_request, aux_req: slot_a_aux_request,
                     oc_aux: slot_a_aux_overcurrent, oc_high: slot_a_high_rail_overcurrent,
                     oc_low: slot_a_low_rail_overcurrent, smc: serial_management_control[0]};
    assign raw.b = '{main_req: slot_b_main_request, aux_req: slot_b_aux_request,
                     oc_aux: slot_b_aux_overcurrent, oc_high: slot_b_high_rail_overcurrent,
                     oc_low: slot_b_low_rail_overcurrent, smc: serial_management_control[1]};
    assign raw.a_main_on = slot_a_main_power;
    assign raw.a_aux_on = slot_a_aux_power;
    assign raw.b_main_good = slot_b_main_good;
    assign raw.b_aux_good = slot_b_aux_good;
    assign raw.b_override_n = slot_b_override_n;

    pin_sync #(
        .WIDTH($bits(pins_s)),
        .RESET_VAL(`PIN_SYNC_RESET)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .pin(raw),
        .level(sp)
    );

    // Per-slot views so both slots share one description
    assign slot_in[`SLOT_A] = sp.a;
    assign slot_in[`SLOT_B] = sp.b;
    assign slot_main_on = {slot_b_main_power, sp.a_main_on}; // see [RULE_10]
    assign slot_aux_on = {slot_b_aux_power, sp.a_aux_on}; // see [RULE_10]

    // Command byte latched as the register pointer
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            pointer <= SEL_NONE;
        else if (clk_en && smb_cmd_valid)
            pointer <= decode_cmd(smb_cmd_byte); // see [RULE_20] see [RULE_08]
    end

    // Write strobes for the selected register
    assign ctrl_wr = clk_en && smb_write_valid && (pointer == SEL_CTRL_B); // see [RULE_08]
    assign stat_wr[`SLOT_A] = clk_en && smb_write_valid && (pointer == SEL_STAT_A);
    assign stat_wr[`SLOT_B] = clk_en && smb_write_valid && (pointer == SEL_STAT_B);

    // Writable control bits; reserved and power-good bits take no write
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            ctrl_b <= `CTRL_WR_RESET; // see [RULE_05]
        else if (ctrl_wr)
            ctrl_b <= smb_write_data[`CTRL_GATE_BIT:`CTRL_AUX_BIT]; // see [RULE_19]
    end

    // Override acts only while low and not gated off
    assign override_active = !sp.b_override_n && !ctrl_b[`CTRL_GATE_BIT]; // see [RULE_03]

    // Slot B supply outputs follow the enables, or all on under override
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            slot_b_aux_power <= 1'b0;
            slot_b_main_power <= 1'b0;
        end
        else if (clk_en)
        begin
            slot_b_aux_power <= ctrl_b[`CTRL_AUX_BIT] || override_active; // see [RULE_01]
            slot_b_main_power <= ctrl_b[`CTRL_MAIN_BIT] || override_active; // see [RULE_02]
        end
    end

    // Power-good pulls low only when both flags are good and no override acts
    assign next_pg_oe = sp.b_main_good && sp.b_aux_good && !override_active; // see [RULE_06]

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            slot_b_power_good_n_oe <= 1'b0;
        else if (clk_en)
            slot_b_power_good_n_oe <= next_pg_oe; // see [RULE_07]
    end

    // Sticky overcurrent flags: a new event wins over a same-cycle clear
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            oc_flag[`SLOT_A] <= `OC_RESET;
            oc_flag[`SLOT_B] <= `OC_RESET;
        end
        else if (clk_en)
        begin
            for (int s = 0; s < 2; s++)
            begin
                logic [2:0] hit;
                logic [2:0] clr;
                hit = {slot_in[s].oc_aux, slot_in[s].oc_high, slot_in[s].oc_low}; // see [RULE_11]
                clr = {smb_write_data[`ST_AUX_OC_BIT], smb_write_data[`ST_HIGH_OC_BIT],
                       smb_write_data[`ST_LOW_OC_BIT]} & {3{stat_wr[s]}};
                oc_flag[s] <= (oc_flag[s] & ~clr) | hit; // see [RULE_12] see [RULE_18]
            end
        end
    end

    // Fault latches by cause; each cause clears on its own request going low
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            main_flt <= 2'h0;
            aux_flt <= 2'h0;
        end
        else if (clk_en)
        begin
            for (int s = 0; s < 2; s++)
            begin
                if (slot_in[s].smc)
                begin
                    main_flt[s] <= 1'b0; // see [RULE_16]
                    aux_flt[s] <= 1'b0;
                end
                else
                begin
                    if (slot_in[s].oc_high || slot_in[s].oc_low)
                        main_flt[s] <= 1'b1;
                    else if (!slot_in[s].main_req)
                        main_flt[s] <= 1'b0; // see [RULE_14]
                    if (slot_in[s].oc_aux)
                        aux_flt[s] <= 1'b1;
                    else if (!slot_in[s].aux_req)
                        aux_flt[s] <= 1'b0; // see [RULE_14] see [RULE_15]
                end
            end
        end
    end

    // Fault outputs depend on latches and pins only, never on host access
    assign next_fault_oe[`SLOT_A] = (main_flt[`SLOT_A] || aux_flt[`SLOT_A])
                                    && !sp.a.smc; // see [RULE_13] see [RULE_16]
    assign next_fault_oe[`SLOT_B] = (main_flt[`SLOT_B] || aux_flt[`SLOT_B])
                                    && !sp.b.smc && sp.b_override_n; // see [RULE_17]

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            fault_oe <= 2'h0;
        else if (clk_en)
            fault_oe <= next_fault_oe;
    end

    // Open-drain pins only ever pull low
    assign slot_a_fault_n_oe = fault_oe[`SLOT_A];
    assign slot_b_fault_n_oe = fault_oe[`SLOT_B];
    assign slot_a_fault_n_drive = 1'b0;
    assign slot_b_fault_n_drive = 1'b0;
    assign slot_b_power_good_n_drive = 1'b0;
    assign alert_n_drive = 1'b0;

    // Alert pulls low while any overcurrent flag stands
    assign alert_n_oe = |{oc_flag[`SLOT_A], oc_flag[`SLOT_B]}; // see [RULE_12]

    // Read data captured at the read strobe
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            smb_read_data <= `REG_RESET;
        else if (clk_en && smb_read_valid)
        begin
            case (pointer)
                SEL_CTRL_B:
                begin
                    smb_read_data <= `REG_RESET; // see [RULE_19]
                    smb_read_data[`CTRL_AUX_GOOD_BIT] <= sp.b_aux_good; // see [RULE_04]
                    smb_read_data[`CTRL_MAIN_GOOD_BIT] <= sp.b_main_good;
                    smb_read_data[`CTRL_GATE_BIT:`CTRL_AUX_BIT] <= ctrl_b;
                end
                SEL_STAT_A:
                    smb_read_data <= status_word(fault_oe[`SLOT_A], slot_main_on[`SLOT_A],
                                                 slot_aux_on[`SLOT_A],
                                                 oc_flag[`SLOT_A]); // see [RULE_09]
                SEL_STAT_B:
                    smb_read_data <= status_word(fault_oe[`SLOT_B], slot_main_on[`SLOT_B],
                                                 slot_aux_on[`SLOT_B],
                                                 oc_flag[`SLOT_B]); // see [RULE_18]
                default:
                    smb_read_data <= `REG_RESET;
            endcase
        end
    end

    // Checks on the register and pin behaviour
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    property p_reset_clear;
        $fell(reset) |-> ctrl_b == `CTRL_WR_RESET && !slot_b_main_power
            && !slot_b_aux_power && oc_flag[`SLOT_B] == `OC_RESET;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("state not cleared by reset"); // see [RULE_05]

    property p_aux_on;
        clk_en && ctrl_b[`CTRL_AUX_BIT] |=> slot_b_aux_power;
    endproperty
    a_aux_on: assert property (p_aux_on) else $error("aux output not on"); // see [RULE_01]

    property p_main_follow;
        clk_en && !override_active |=> slot_b_main_power == $past(ctrl_b[`CTRL_MAIN_BIT]);
    endproperty
    a_main_follow: assert property (p_main_follow) else $error("main output wrong"); // see [RULE_02]

    property p_gated;
        clk_en && ctrl_b[`CTRL_GATE_BIT] |=> slot_b_power_good_n_oe
            == ($past(sp.b_main_good) && $past(sp.b_aux_good));
    endproperty
    a_gated: assert property (p_gated) else $error("gated override not ignored"); // see [RULE_03]

    property p_pg_forced;
        clk_en && !sp.b_override_n && !ctrl_b[`CTRL_GATE_BIT] |=> !slot_b_power_good_n_oe;
    endproperty
    a_pg_forced: assert property (p_pg_forced) else $error("power good not forced off"); // see [RULE_07]

    property p_rsv_zero;
        clk_en && smb_read_valid && pointer == SEL_CTRL_B
            |=> smb_read_data[`CTRL_RSV_HI:`CTRL_RSV_LO] == 3'h0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits not zero"); // see [RULE_19]

    property p_oc_set;
        clk_en && sp.b.oc_low |=> oc_flag[`SLOT_B][`OC_LOW] && alert_n_oe;
    endproperty
    a_oc_set: assert property (p_oc_set) else $error("overcurrent flag not set"); // see [RULE_11]

    property p_w1c;
        stat_wr[`SLOT_A] && smb_write_data[`ST_HIGH_OC_BIT] && !sp.a.oc_high
            |=> !oc_flag[`SLOT_A][`OC_HIGH];
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear"); // see [RULE_12]

    property p_stat_fault;
        clk_en && smb_read_valid && pointer == SEL_STAT_B
            |=> smb_read_data[`ST_FAULT_BIT] == $past(slot_b_fault_n_oe);
    endproperty
    a_stat_fault: assert property (p_stat_fault) else $error("fault bit mismatch"); // see [RULE_09]

    property p_fault_hold;
        clk_en && slot_b_fault_n_oe && sp.b.main_req && sp.b.aux_req && $past(sp.b.main_req)
            && $past(sp.b.aux_req) && !sp.b.smc && sp.b_override_n |=> slot_b_fault_n_oe;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault cleared early"); // see [RULE_14]

    property p_smc_idle;
        clk_en && sp.a.smc |=> !slot_a_fault_n_oe;
    endproperty
    a_smc_idle: assert property (p_smc_idle) else $error("fault active under management"); // see [RULE_16]

    property p_override_release;
        clk_en && !sp.b_override_n |=> !slot_b_fault_n_oe;
    endproperty
    a_override_release: assert property (p_override_release) else $error("fault not released"); // see [RULE_17]

endmodule // hotplug_slot_regs

`default_nettype wire

// ---- rtl/hotplug_cfg.svh ----
`ifndef HOTPLUG_CFG_SVH
`define HOTPLUG_CFG_SVH

// Command bytes selecting the registers
`define CMD_CTRL_B 8'h03
`define CMD_STAT_A 8'h04
`define CMD_STAT_B 8'h05

// Power-up value of every register and read value of unmapped commands
`define REG_RESET 8'h00

// Control register fields
`define CTRL_AUX_BIT 0
`define CTRL_MAIN_BIT 1
`define CTRL_GATE_BIT 2
`define CTRL_RSV_HI 5
`define CTRL_RSV_LO 3
`define CTRL_MAIN_GOOD_BIT 6
`define CTRL_AUX_GOOD_BIT 7
`define CTRL_WR_RESET 3'h0

// Status register fields
`define ST_LOW_OC_BIT 0
`define ST_RSV1_BIT 1
`define ST_HIGH_OC_BIT 2
`define ST_RSV3_BIT 3
`define ST_AUX_OC_BIT 4
`define ST_AUX_ON_BIT 5
`define ST_MAIN_ON_BIT 6
`define ST_FAULT_BIT 7

// Overcurrent flag vector index within one slot
`define OC_LOW 0
`define OC_HIGH 1
`define OC_AUX 2
`define OC_RESET 3'h0

// Slot numbers
`define SLOT_A 0
`define SLOT_B 1

// Synchroniser reset image: only the active-low override idles high
`define PIN_SYNC_RESET 17'h00001

`endif

// ---- rtl/hotplug_pkg.sv ----
`default_nettype none

package hotplug_pkg;

    // Register selected by the latched command byte
    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_CTRL_B = 2'b01,
        SEL_STAT_A = 2'b10,
        SEL_STAT_B = 2'b11
    } reg_sel_e;

    // Request, fault and mode pins of one slot
    typedef struct packed {
        logic main_req;
        logic aux_req;
        logic oc_aux;
        logic oc_high;
        logic oc_low;
        logic smc;
    } slot_pins_s;

    // All pins that cross into the clock domain
    typedef struct packed {
        slot_pins_s a;
        slot_pins_s b;
        logic a_main_on;
        logic a_aux_on;
        logic b_main_good;
        logic b_aux_good;
        logic b_override_n;
    } pins_s;

endpackage

`default_nettype wire

// ---- rtl/pin_sync.sv ----
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // Three-stage chain; the first stage feeds only the second
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
            stage3 <= RESET_VAL;
        end
        else if (clk_en)
        begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A bit moves only once the second and third stages agree
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            level <= RESET_VAL;
        else if (clk_en)
            level <= (stage3 & ~(stage2 ^ stage3)) | (level & (stage2 ^ stage3));
    end

endmodule // pin_sync

`default_nettype wire

// ---- dv/hotplug_host_model.sv ----
`default_nettype none
// Host byte port and board request pins facing the slot register block
module hotplug_host_model (
    input wire logic sys_clk,
    input wire logic [1:0] smc,
    input wire logic [3:0] want_req,
    output logic [3:0] req,
    output logic cmd_v,
    output logic [7:0] cmd_b,
    output logic wr_v,
    output logic [7:0] wr_d,
    output logic rd_v,
    output logic answer
);
    timeunit 1ns;
    timeprecision 1ns;

    // Request order {b_aux, b_main, a_aux, a_main}; a managed slot keeps its requests low
    assign req = want_req & {{2{~smc[1]}}, {2{~smc[0]}}};

    // Idle port at time zero
    initial
    begin
        cmd_v = 1'h0;
        cmd_b = 8'h00;
        wr_v = 1'h0;
        wr_d = 8'h00;
        rd_v = 1'h0;
        answer = 1'h0;
    end

    // Byte write: command byte, then data byte; released bytes show inverted junk
    task automatic write_reg(input logic [7:0] c, input logic [7:0] d);
        @(negedge sys_clk);
        cmd_v <= 1'h1;
        cmd_b <= c;
        @(negedge sys_clk);
        cmd_v <= 1'h0;
        cmd_b <= ~c;
        wr_v <= 1'h1;
        wr_d <= d;
        @(negedge sys_clk);
        wr_v <= 1'h0;
        wr_d <= ~d;
    endtask

    // Byte read: command byte, then read strobe; answer marks settled read data
    task automatic read_reg(input logic [7:0] c);
        @(negedge sys_clk);
        cmd_v <= 1'h1;
        cmd_b <= c;
        @(negedge sys_clk);
        cmd_v <= 1'h0;
        cmd_b <= ~c;
        rd_v <= 1'h1;
        @(negedge sys_clk);
        rd_v <= 1'h0;
        answer <= 1'h1;
        @(negedge sys_clk);
        answer <= 1'h0;
    endtask
endmodule // hotplug_host_model
`default_nettype wire

// ---- dv/test_hotplug_slot_regs.sv ----
`include "hotplug_cfg.svh"
`default_nettype none
module test_hotplug_slot_regs
    import hotplug_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk, reset, ce, cmd_v, wr_v, rd_v, answer;
    logic [3:0] drv; // Open-drain pin values
    logic [7:0] cmd_b, wr_d, rdata, d;
    logic [1:0] smc;
    logic [3:0] want, req;
    logic [5:0] oc; // {b_aux, b_high, b_low, a_aux, a_high, a_low}
    logic a_mp, a_ap, b_mg, b_ag, b_ovr_n;
    logic alert_oe, b_mp, b_ap, pg_oe, fa_oe, fb_oe;
    int err_total, tests_run;
    logic [7:0] expq[$];

    hotplug_host_model host (.sys_clk(sys_clk), .smc(smc), .want_req(want), .req(req),
        .cmd_v(cmd_v), .cmd_b(cmd_b), .wr_v(wr_v), .wr_d(wr_d), .rd_v(rd_v), .answer(answer));

    hotplug_slot_regs uut (.sys_clk(sys_clk), .reset(reset), .clk_en(ce),
        .smb_cmd_valid(cmd_v), .smb_cmd_byte(cmd_b), .smb_write_valid(wr_v),
        .smb_write_data(wr_d), .smb_read_valid(rd_v), .smb_read_data(rdata),
        .alert_n_drive(drv[0]), .alert_n_oe(alert_oe),
        .slot_a_main_request(req[0]), .slot_a_aux_request(req[1]),
        .slot_b_main_request(req[2]), .slot_b_aux_request(req[3]),
        .slot_a_aux_overcurrent(oc[2]), .slot_a_high_rail_overcurrent(oc[1]),
        .slot_a_low_rail_overcurrent(oc[0]), .slot_b_aux_overcurrent(oc[5]),
        .slot_b_high_rail_overcurrent(oc[4]), .slot_b_low_rail_overcurrent(oc[3]),
        .serial_management_control(smc), .slot_a_main_power(a_mp), .slot_a_aux_power(a_ap),
        .slot_b_main_good(b_mg), .slot_b_aux_good(b_ag), .slot_b_override_n(b_ovr_n),
        .slot_b_main_power(b_mp), .slot_b_aux_power(b_ap),
        .slot_b_power_good_n_drive(drv[1]), .slot_b_power_good_n_oe(pg_oe),
        .slot_a_fault_n_drive(drv[2]), .slot_a_fault_n_oe(fa_oe),
        .slot_b_fault_n_drive(drv[3]), .slot_b_fault_n_oe(fb_oe));

    // 20 MHz clock
    initial
    begin
        sys_clk = 1'h0;
        forever #25 sys_clk = ~sys_clk;
    end

    // One comparison, counted
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask

    // Note the expected byte, then read through the host
    task automatic rd(input logic [7:0] c, input logic [7:0] e);
        expq.push_back(e);
        host.read_reg(c);
    endtask

    // Pins take up to four edges to synchronise, outputs one more, fault outputs two more
    task automatic pins_wait();
        repeat (6) @(negedge sys_clk);
    endtask

    // Verdict and end of run
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Compare each settled read answer with the oldest note
    always @(posedge sys_clk)
    begin
        if (answer === 1'h1)
        begin
            if (expq.size() == 0)
                check("unnoted read", 8'h00, 8'hff);
            else
                check("read data", expq.pop_front(), rdata);
        end
    end

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        $display("unexpected run length expected 20000 seen more");
        final_report();
    end

    // Main sequence
    initial
    begin
        err_total = 0;
        tests_run = 0;
        reset = 1'h1;
        ce = 1'h1;
        smc = 2'h0;
        want = 4'h0;
        oc = 6'h00;
        {a_mp, a_ap, b_mg, b_ag} = 4'h0;
        b_ovr_n = 1'h1;
        void'($urandom(50242));
        repeat (2) @(negedge sys_clk);
        reset = 1'h0;
        pins_wait();
        // Power-up values, open-drain levels, command decode, unmapped write ignored
        check("main power", 8'h00, 8'(b_mp));
        check("aux power", 8'h00, 8'(b_ap));
        check("drive values", 8'h00, 8'(drv));
        host.write_reg(8'h07, 8'hff);
        rd(`CMD_CTRL_B, 8'h00);
        rd(`CMD_STAT_A, 8'h00);
        rd(`CMD_STAT_B, 8'h00);
        rd(8'h07, 8'h00);
        // Random control writes; reserved and flag bits ignore writes
        for (int i = 0; i < 6; i++)
        begin
            d = 8'($urandom);
            host.write_reg(`CMD_CTRL_B, d);
            rd(`CMD_CTRL_B, {5'h00, d[2:0]});
            check("aux power", 8'(d[0]), 8'(b_ap));
            check("main power", 8'(d[1]), 8'(b_mp));
            rd(`CMD_STAT_B, {1'h0, d[1], d[0], 5'h00});
        end
        // Power-good flags and the power-good output
        host.write_reg(`CMD_CTRL_B, 8'h00);
        {b_mg, b_ag} = 2'h3;
        pins_wait();
        rd(`CMD_CTRL_B, 8'hc0);
        check("power good", 8'h01, 8'(pg_oe));
        b_ag = 1'h0;
        pins_wait();
        check("power good", 8'h00, 8'(pg_oe));
        rd(`CMD_CTRL_B, 8'h40);
        b_ag = 1'h1;
        // Override acts while ungated, ignored once gated
        b_ovr_n = 1'h0;
        pins_wait();
        check("power good", 8'h00, 8'(pg_oe));
        host.write_reg(`CMD_CTRL_B, 8'h04);
        pins_wait();
        check("power good", 8'h01, 8'(pg_oe));
        check("main power", 8'h00, 8'(b_mp));
        b_ovr_n = 1'h1;
        // Clock enable low freezes the port: this write is not taken
        ce = 1'h0;
        host.write_reg(`CMD_CTRL_B, 8'h03);
        ce = 1'h1;
        rd(`CMD_CTRL_B, 8'hc4);
        check("main power", 8'h00, 8'(b_mp));
        // Slot A main overcurrent: flag, alert, fault latch and its clearing
        a_mp = 1'h1;
        want = 4'h3;
        pins_wait();
        oc[1] = 1'h1;
        pins_wait();
        oc[1] = 1'h0;
        pins_wait();
        rd(`CMD_STAT_A, 8'hc4);
        check("alert", 8'h01, 8'(alert_oe));
        check("fault a", 8'h01, 8'(fa_oe));
        host.write_reg(`CMD_STAT_A, 8'hff);
        rd(`CMD_STAT_A, 8'hc0);
        check("alert", 8'h00, 8'(alert_oe));
        check("fault a", 8'h01, 8'(fa_oe));
        want = 4'h1;
        pins_wait();
        check("fault a", 8'h01, 8'(fa_oe));
        want = 4'h0;
        pins_wait();
        check("fault a", 8'h00, 8'(fa_oe));
        rd(`CMD_STAT_A, 8'h40);
        // Slot B main and aux faults together; override releases the fault pin
        want = 4'hc;
        pins_wait();
        oc[5] = 1'h1;
        oc[3] = 1'h1;
        pins_wait();
        oc = 6'h00;
        pins_wait();
        rd(`CMD_STAT_B, 8'h91);
        check("fault b", 8'h01, 8'(fb_oe));
        b_ovr_n = 1'h0;
        pins_wait();
        check("fault b", 8'h00, 8'(fb_oe));
        b_ovr_n = 1'h1;
        pins_wait();
        want = 4'h8;
        pins_wait();
        check("fault b", 8'h01, 8'(fb_oe));
        host.write_reg(`CMD_STAT_B, 8'hff);
        rd(`CMD_STAT_B, 8'h80);
        want = 4'h0;
        pins_wait();
        check("fault b", 8'h00, 8'(fb_oe));
        rd(`CMD_STAT_B, 8'h00);
        // Both slots under serial management: flags set, fault outputs stay idle
        smc = 2'h3;
        a_ap = 1'h1;
        want = 4'hf;
        pins_wait();
        oc = 6'h09;
        pins_wait();
        oc = 6'h00;
        pins_wait();
        rd(`CMD_STAT_A, 8'h61);
        rd(`CMD_STAT_B, 8'h01);
        check("fault a", 8'h00, 8'(fa_oe));
        check("fault b", 8'h00, 8'(fb_oe));
        host.write_reg(`CMD_STAT_A, 8'h01);
        rd(`CMD_STAT_A, 8'h60);
        check("alert", 8'h01, 8'(alert_oe));
        host.write_reg(`CMD_STAT_B, 8'h01);
        rd(`CMD_STAT_B, 8'h00);
        check("alert", 8'h00, 8'(alert_oe));
        // Drain outstanding notes
        for (int k = 0; k < 20 && expq.size() > 0; k++)
            @(negedge sys_clk);
        if (expq.size() > 0)
            check("pending reads", 8'h00, 8'(expq.size()));
        final_report();
    end
endmodule // test_hotplug_slot_regs
`default_nettype wire
